// ==== line_threshold_pkg.sv ====
/*
  package for the line threshold interrupt and hybrid tap register bank:
  register addresses, field positions, reset values and state types.
  assumes an 8-bit register address space reached by a simple
  synchronous read/write register port.
*/
package line_threshold_pkg;

  localparam int AddrW = 8;
  localparam int DataW = 8;

  // register addresses
  localparam logic [7:0] AddrThreshLevel = 8'h2b;
  localparam logic [7:0] AddrThreshCtrl = 8'h2c;
  localparam logic [7:0] AddrTapOne = 8'h2d;
  localparam logic [7:0] AddrTapTwo = 8'h2e;
  localparam logic [7:0] AddrTapThree = 8'h2f;

  // threshold control field positions
  localparam int BitDirection = 0;
  localparam int BitIrqMask = 1;
  localparam int BitMeasSel = 2;
  localparam int BitCrossed = 3;

  localparam logic [7:0] ResetValue = 8'h00;
  localparam logic [7:0] ZeroByte = 8'h00;
  localparam logic [7:0] CtrlWriteMask = 8'h07;

  // index of each tap in the small coefficient store
  localparam logic [1:0] TapIdxOne = 2'h0;
  localparam logic [1:0] TapIdxTwo = 2'h1;
  localparam logic [1:0] TapIdxThree = 2'h2;
  localparam int TapCount = 3;

  typedef enum logic [1:0] {
    CmpIdle,
    CmpEval
  } cmp_state_t;

endpackage

// ==== hybrid_tap_store.sv ====
/*
  three-entry store of 8-bit hybrid tap coefficients with registered
  read data and a per-tap active flag.
  assumes single-cycle writes from the register port of its parent.
*/
`timescale 1ns/1ps
module hybrid_tap_store
  import line_threshold_pkg::*;
(
  input wire logic sys_clk, // device clock
  input wire logic rst, // async reset, active high
  input wire logic wrEn, // write strobe
  input wire logic [1:0] wrIdx, // tap written
  input wire logic [7:0] wrData, // coefficient written
  input wire logic [1:0] rdIdx, // tap read
  output logic [7:0] rdData_q, // registered read coefficient
  output logic [TapCount-1:0] tapActive_q // tap contributes when set
);

  logic [7:0] mem_q [TapCount];
  logic [7:0] mem_d [TapCount];
  logic [7:0] rdData_d;
  logic [TapCount-1:0] tapActive_d;

  always_comb
  begin
    for (int i = 0; i < TapCount; i++)
    begin
      mem_d[i] = mem_q[i];
      if (wrEn && wrIdx == 2'(i))
        mem_d[i] = wrData;
    end
    rdData_d = ZeroByte;
    if (int'(rdIdx) < TapCount)
      rdData_d = mem_q[rdIdx];
    for (int i = 0; i < TapCount; i++)
      tapActive_d[i] = (mem_d[i] != ZeroByte);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < TapCount; i++)
        mem_q[i] <= ResetValue;
      rdData_q <= ResetValue;
      tapActive_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      rdData_q <= rdData_d;
      tapActive_q <= tapActive_d;
    end
  end

endmodule

// ==== line_threshold_irq_hybrid_taps.sv ====
/*
  line current/voltage threshold interrupt control plus the first three
  hybrid tap coefficient registers.
  assumes a synchronous register port (regAddr, regWrEn, regRdEn) on
  sys_clk, and measurement values that arrive as signed bytes with a
  one-cycle update strobe each.
*/
`timescale 1ns/1ps
module line_threshold_irq_hybrid_taps
  import line_threshold_pkg::*;
(
  input wire logic sys_clk, // device clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire logic [7:0] regAddr, // register address
  input wire logic regWrEn, // write strobe
  input wire logic [7:0] regWrData, // write data
  input wire logic regRdEn, // read strobe
  output logic [7:0] regRdData_q, // read data, two edges after strobe
  input wire logic [7:0] line_current_value, // signed line current
  input wire logic lineCurrentUpd, // current value updated
  input wire logic [7:0] line_voltage_value, // signed line voltage
  input wire logic lineVoltageUpd, // voltage value updated
  input wire logic global_irq_enable, // global interrupt enable
  output logic analog_out_irq_pin_q, // interrupt level, active high
  output logic [2:0] tapActive_q // taps with nonzero coefficient
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] absVal(input logic [7:0] v);
    // -128 saturates to 127 so it stays within 8 bits
    if (!v[7])
      absVal = v;
    else if (v == 8'h80)
      absVal = 8'h7f;
    else
      absVal = 8'(-v);
  endfunction

  function automatic logic isTrig(input logic [7:0] mag,
                                  input logic [7:0] lvl,
                                  input logic dirUp);
    if (dirUp)
      isTrig = (mag > lvl);
    else
      isTrig = (mag < lvl);
  endfunction

  function automatic logic isTapAddr(input logic [7:0] a);
    isTapAddr = (a == AddrTapOne || a == AddrTapTwo || a == AddrTapThree);
  endfunction

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] threshold_level_q, threshold_level_d;
  logic threshold_crossed_flag_q, threshold_crossed_flag_d;
  logic measure_select_q, measure_select_d;
  logic threshold_irq_mask_q, threshold_irq_mask_d;
  logic threshold_direction_q, threshold_direction_d;
  logic irq_d;
  logic [7:0] rdMux;
  logic rdTap_q, rdTap_d;
  logic rdPend_q, rdPend_d;
  logic [7:0] rdLocal_q, rdLocal_d;
  logic [7:0] regRdData_d;
  logic [7:0] tapRdData;
  logic [2:0] tapActiveStore;
  logic tapWr;
  logic [1:0] tapIdx;
  cmp_state_t cmpState_q, cmpState_d;
  logic [7:0] sample_q, sample_d;
  logic trigger;
  logic wrCtrl;

  assign wrCtrl = regWrEn && regAddr == AddrThreshCtrl;

  // ------------------------------------------------------------
  // measurement capture and compare
  // ------------------------------------------------------------
  // the sample is latched on the update strobe and compared a cycle later,
  // which keeps the abs/compare path off the measurement inputs
  always_comb
  begin
    cmpState_d = CmpIdle;
    sample_d = sample_q;
    trigger = 1'b0;
    case (cmpState_q)
      CmpIdle:
      begin
      end
      CmpEval:
        trigger = isTrig(absVal(sample_q), threshold_level_q,
                         threshold_direction_q);
      default:
        cmpState_d = CmpIdle;
    endcase
    if (!measure_select_q && lineCurrentUpd)
    begin
      sample_d = line_current_value;
      cmpState_d = CmpEval;
    end
    else if (measure_select_q && lineVoltageUpd)
    begin
      sample_d = line_voltage_value;
      cmpState_d = CmpEval;
    end
  end

  // ------------------------------------------------------------
  // control register and interrupt
  // ------------------------------------------------------------
  always_comb
  begin
    threshold_level_d = threshold_level_q;
    measure_select_d = measure_select_q;
    threshold_irq_mask_d = threshold_irq_mask_q;
    threshold_direction_d = threshold_direction_q;
    threshold_crossed_flag_d = threshold_crossed_flag_q;
    if (regWrEn && regAddr == AddrThreshLevel)
      threshold_level_d = regWrData;
    if (wrCtrl)
    begin
      measure_select_d = regWrData[BitMeasSel];
      threshold_irq_mask_d = regWrData[BitIrqMask];
      threshold_direction_d = regWrData[BitDirection];
      // writing one leaves the flag alone; only zero clears it
      if (!regWrData[BitCrossed])
        threshold_crossed_flag_d = 1'b0;
    end
    if (trigger)
      threshold_crossed_flag_d = 1'b1; // set wins over clear
    // level interrupt follows flag, mask and global enable
    irq_d = threshold_crossed_flag_d && threshold_irq_mask_d
            && global_irq_enable;
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  assign tapWr = regWrEn && isTapAddr(regAddr);
  assign tapIdx = regAddr == AddrTapOne ? TapIdxOne :
                  regAddr == AddrTapTwo ? TapIdxTwo : TapIdxThree;

  always_comb
  begin
    rdLocal_d = rdLocal_q;
    rdTap_d = rdTap_q;
    rdPend_d = regRdEn;
    rdMux = ZeroByte;
    if (regRdEn)
    begin
      rdTap_d = isTapAddr(regAddr);
      if (regAddr == AddrThreshLevel)
        rdMux = threshold_level_q;
      else if (regAddr == AddrThreshCtrl)
      begin
        rdMux[BitCrossed] = threshold_crossed_flag_q;
        rdMux[BitMeasSel] = measure_select_q;
        rdMux[BitIrqMask] = threshold_irq_mask_q;
        rdMux[BitDirection] = threshold_direction_q;
      end
      rdLocal_d = rdMux;
    end
    // the store registers its byte on the strobe edge, so every read is
    // answered one edge later and then held until the next read; a
    // change of address alone never disturbs the answer
    regRdData_d = regRdData_q;
    if (rdPend_q)
      regRdData_d = rdTap_q ? tapRdData : rdLocal_q;
  end

  // the store is addressed straight from the bus on the strobe edge
  hybrid_tap_store u_taps (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(tapWr),
    .wrIdx(tapIdx),
    .wrData(regWrData),
    .rdIdx(tapIdx),
    .rdData_q(tapRdData),
    .tapActive_q(tapActiveStore)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      threshold_level_q <= ResetValue;
      threshold_crossed_flag_q <= 1'b0;
      measure_select_q <= 1'b0;
      threshold_irq_mask_q <= 1'b0;
      threshold_direction_q <= 1'b0;
      analog_out_irq_pin_q <= 1'b0;
      cmpState_q <= CmpIdle;
      sample_q <= ResetValue;
      rdLocal_q <= ResetValue;
      rdTap_q <= 1'b0;
      rdPend_q <= 1'b0;
      regRdData_q <= ResetValue;
      tapActive_q <= '0;
    end
    else
    begin
      threshold_level_q <= threshold_level_d;
      threshold_crossed_flag_q <= threshold_crossed_flag_d;
      measure_select_q <= measure_select_d;
      threshold_irq_mask_q <= threshold_irq_mask_d;
      threshold_direction_q <= threshold_direction_d;
      analog_out_irq_pin_q <= irq_d;
      cmpState_q <= cmpState_d;
      sample_q <= sample_d;
      rdLocal_q <= rdLocal_d;
      rdTap_q <= rdTap_d;
      rdPend_q <= rdPend_d;
      regRdData_q <= regRdData_d;
      tapActive_q <= tapActiveStore;
    end
  end

endmodule

// ==== line_threshold_props.sv ====
/*
  assertions on the threshold interrupt and tap register bank ports.
  assumes binding into the top module; sees only its ports.
*/
`timescale 1ns/1ps
module line_threshold_props
  import line_threshold_pkg::*;
(
  input wire logic sys_clk, // device clock
  input wire logic rst, // async reset
  input wire logic [7:0] regAddr, // register address
  input wire logic regWrEn, // write strobe
  input wire logic [7:0] regWrData, // write data
  input wire logic regRdEn, // read strobe
  input wire logic [7:0] regRdData_q, // read data
  input wire logic lineCurrentUpd, // current update
  input wire logic lineVoltageUpd, // voltage update
  input wire logic global_irq_enable, // global enable
  input wire logic analog_out_irq_pin_q, // interrupt pin
  input wire logic [2:0] tapActive_q // tap active flags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ctrlWr;
  logic pin;
  assign ctrlWr = regWrEn && regAddr == AddrThreshCtrl;
  assign pin = analog_out_irq_pin_q;
  // level at 0x2b, taps at 0x2d..0x2f
  sequence wr_store;
    regWrEn && (regAddr == AddrThreshLevel
      || (regAddr[7:2] == 6'h0b && regAddr[1:0] != 2'h0));
  endsequence
  sequence rd_same;
    regRdEn && !regWrEn && regAddr == $past(regAddr, 2);
  endsequence
  readback_a: assert property (wr_store ##1 !regWrEn ##1 rd_same
    |=> ##1 regRdData_q == $past(regWrData, 4)) else $error("byte not kept");
  tap_on_a: assert property (regWrEn && regAddr == AddrTapOne
    && regWrData != ZeroByte |-> ##[1:2] tapActive_q[0])
    else $error("tap one not active");
  tap_off_a: assert property (regWrEn && regAddr == AddrTapThree
    && regWrData == ZeroByte |-> ##[1:2] !tapActive_q[2])
    else $error("zero tap still active");
  pin_rise_a: assert property ($rose(pin) |-> $past(global_irq_enable))
    else $error("pin rose while disabled");
  pin_off_a: assert property (!global_irq_enable |=> !pin)
    else $error("pin high while disabled");
  mask_off_a: assert property (ctrlWr && !regWrData[BitIrqMask]
    |-> ##2 !pin) else $error("masked pin high");
  pin_hold_a: assert property (pin && global_irq_enable && !ctrlWr
    && !$past(ctrlWr) |=> pin) else $error("flag cleared by hardware");
  pin_cause_a: assert property ($rose(pin) |->
    $past(lineCurrentUpd, 2) || $past(lineCurrentUpd, 3)
    || $past(lineVoltageUpd, 2) || $past(lineVoltageUpd, 3)
    || $past(ctrlWr) || !$past(global_irq_enable, 2))
    else $error("pin rose without cause");
  ctrl_rsvd_a: assert property (regRdEn && regAddr == AddrThreshCtrl
    |=> ##1 regRdData_q[7:4] == 4'h0) else $error("reserved bits set");
endmodule
bind line_threshold_irq_hybrid_taps line_threshold_props i_props (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
  .lineCurrentUpd(lineCurrentUpd), .lineVoltageUpd(lineVoltageUpd),
  .global_irq_enable(global_irq_enable),
  .analog_out_irq_pin_q(analog_out_irq_pin_q), .tapActive_q(tapActive_q));

// ==== tb_line_threshold_irq_hybrid_taps.sv ====
/*
  self-checking bench for the threshold interrupt and tap registers.
  assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
module tb_line_threshold_irq_hybrid_taps
  import line_threshold_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData_q;
  logic [7:0] curVal = 8'h00;
  logic curUpd = 1'b0;
  logic [7:0] voltVal = 8'h00;
  logic voltUpd = 1'b0;
  logic irqEn = 1'b0;
  logic irqPin;
  logic [2:0] tapActive_q;
  int failures = 0;
  int num_checks = 0;
  // en, mask, select, direction, current, voltage
  logic [19:0] cases [8] = '{20'hcf000, 20'hc2000, 20'hd8000, 20'hd107f,
    20'he0140, 20'hf7fc0, 20'h8f000, 20'h4f000};
  always #2 sys_clk = ~sys_clk;
  line_threshold_irq_hybrid_taps i_dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .line_current_value(curVal), .lineCurrentUpd(curUpd),
    .line_voltage_value(voltVal), .lineVoltageUpd(voltUpd),
    .global_irq_enable(irqEn), .analog_out_irq_pin_q(irqPin),
    .tapActive_q(tapActive_q));
  task automatic end_of_test;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(regRdData_q, exp);
  endtask
  // current then voltage, back to back; flag settles two edges later
  task automatic meas(input logic [7:0] c, input logic [7:0] v);
    @(posedge sys_clk);
    curVal <= c;
    curUpd <= 1'b1;
    @(posedge sys_clk);
    curUpd <= 1'b0;
    voltVal <= v;
    voltUpd <= 1'b1;
    @(posedge sys_clk);
    voltUpd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // -128 saturates to 127; equal to the level never triggers
  function automatic logic trig(logic sel, logic dir, logic [7:0] c,
    logic [7:0] v);
    logic [7:0] s;
    logic [7:0] a;
    s = sel ? v : c;
    a = s[7] ? ((s == 8'h80) ? 8'h7f : -s) : s;
    return dir ? (a > 8'h20) : (a < 8'h20);
  endfunction
  initial
  begin
    #20000;
    failures++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [19:0] t;
    logic e;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd_chk(AddrThreshLevel + 8'(i), ResetValue);
    wr(8'h30, 8'h5a);
    rd_chk(8'h30, ZeroByte);
    wr(AddrThreshCtrl, 8'hf8);
    rd_chk(AddrThreshCtrl, ZeroByte);
    for (int i = 0; i < 3; i++)
    begin
      wr(AddrTapOne + 8'(i), 8'h81 + 8'(i));
      rd_chk(AddrTapOne + 8'(i), 8'h81 + 8'(i));
      check({5'h0, tapActive_q}, 8'h01 << i);
      wr(AddrTapOne + 8'(i), ZeroByte);
      rd_chk(AddrTapOne + 8'(i), ZeroByte);
      check({5'h0, tapActive_q}, ZeroByte);
    end
    wr(AddrThreshLevel, 8'h20);
    rd_chk(AddrThreshLevel, 8'h20);
    foreach (cases[k])
    begin
      t = cases[k];
      @(posedge sys_clk);
      irqEn <= t[19];
      wr(AddrThreshCtrl, {5'h0, t[17], t[18], t[16]});
      meas(t[15:8], t[7:0]);
      e = trig(t[17], t[16], t[15:8], t[7:0]);
      check({7'h0, irqPin}, {7'h0, e & t[18] & t[19]});
      rd_chk(AddrThreshCtrl, {4'h0, e, t[17], t[18], t[16]});
    end
    @(posedge sys_clk);
    irqEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h0, irqPin}, 8'h01);
    meas(8'h7f, 8'h7f);
    rd_chk(AddrThreshCtrl, 8'h0a);
    check({7'h0, irqPin}, 8'h01);
    wr(AddrThreshCtrl, 8'h02);
    rd_chk(AddrThreshCtrl, 8'h02);
    check({7'h0, irqPin}, ZeroByte);
    end_of_test();
  end
endmodule
